// [pkg/micf_consts.svh]
// constants of the maskable interrupt control flags block
`ifndef MICF_CONSTS_SVH
`define MICF_CONSTS_SVH

// ----------------------------------------
// sources and control byte layout
// ----------------------------------------
`define MICF_NSRC 23
`define MICF_NMKA 16
`define MICF_B_REQ 7
`define MICF_B_MASK 6
`define MICF_B_MACRO 5
`define MICF_B_CTX 4
`define MICF_B_PRHI 1
`define MICF_B_PRLO 0
`define MICF_CTRL_RST 8'h43
`define MICF_CTRL_WMASK 8'hf3

// ----------------------------------------
// register word indexes (byte address = 4 * index)
// ----------------------------------------
`define MICF_W_CTRL0 6'h00
`define MICF_W_MKA 6'h18
`define MICF_W_MKB 6'h19
`define MICF_W_STAT 6'h1a
`define MICF_W_IMSK 6'h1b

// ----------------------------------------
// event status bits
// ----------------------------------------
`define MICF_EV_ACK 0
`define MICF_EV_MEND 1
`define MICF_NEV 2
`define MICF_IMSK_RST 2'h0

`endif

// [pkg/micf_pkg.sv]
// types of the maskable interrupt control flags block
package micf_pkg;
  typedef enum logic [1:0] {
    MICF_VECT  = 2'b00,
    MICF_CTX   = 2'b01,
    MICF_MACRO = 2'b10
  } micf_mode_t;
endpackage

// [hdl/micf_src.sv]
// control byte of one maskable interrupt source
`timescale 1ns/100ps
`default_nettype none
`include "micf_consts.svh"

module micf_src (
  input wire logic clk_i,            // cpu clock
  input wire logic rst_i,            // sync reset, high
  input wire logic set_i,            // source raised its request
  input wire logic ack_clr_i,        // request acknowledged by cpu
  input wire logic wr_ctrl_i,        // write of the control byte
  input wire logic [7:0] wr_dat_i,   // control byte write data
  input wire logic wr_mask_i,        // write through a mask register
  input wire logic mask_dat_i,       // mask bit from mask register
  input wire logic macro_end_i,      // macro service counter hit zero
  output logic [7:0] ctrl_o          // control byte
);

  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl_i) begin
      ctrl_nxt = wr_dat_i & `MICF_CTRL_WMASK;
    end
    if (ack_clr_i && !wr_ctrl_i) begin
      ctrl_nxt[`MICF_B_REQ] = 1'b0;
    end
    // mask lives only here, both paths share the flop
    if (wr_mask_i) begin
      ctrl_nxt[`MICF_B_MASK] = mask_dat_i;
    end
    // hardware end of macro service overrides a software write
    if (macro_end_i) begin
      ctrl_nxt[`MICF_B_MACRO] = 1'b0;
    end
    // a new request wins over any clear in the same cycle
    if (set_i) begin
      ctrl_nxt[`MICF_B_REQ] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `MICF_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign ctrl_o = ctrl_r;

endmodule
`default_nettype wire

// [hdl/micf_top.sv]
// maskable interrupt control flags, arbiter and wishbone register slave
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "micf_consts.svh"

module micf_top (
  input wire logic clk_i,                 // 40 MHz cpu clock
  input wire logic rst_i,                 // sync reset, high
  input wire logic wb_cyc_i,              // wishbone cycle
  input wire logic wb_stb_i,              // wishbone strobe
  input wire logic wb_we_i,               // wishbone write
  input wire logic [7:2] wb_adr_i,        // wishbone word address
  input wire logic [3:0] wb_sel_i,        // wishbone byte selects
  input wire logic [31:0] wb_dat_i,       // wishbone write data
  output logic [31:0] wb_dat_o,           // wishbone read data
  output logic wb_ack_o,                  // wishbone acknowledge
  input wire logic [22:0] src_evt_i,      // request pulses, one per source
  input wire logic ack_i,                 // cpu takes presented request
  input wire logic macro_end_i,           // macro service counter reached 0
  input wire logic [4:0] macro_end_id_i,  // source whose macro service ended
  output logic req_valid_o,               // a request is presented
  output logic [4:0] req_id_o,            // presented source
  output logic [1:0] req_level_o,         // its priority level
  output micf_pkg::micf_mode_t req_mode_o, // its servicing mode
  output logic irq_o                      // unmasked event status pending
);

  localparam int NSRC = `MICF_NSRC;
  localparam int NMKA = `MICF_NMKA;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire logic acc = wb_cyc_i & wb_stb_i;
  wire logic [5:0] widx = wb_adr_i;
  wire logic hit_ctrl = ((widx - `MICF_W_CTRL0) < 6'(NSRC));
  wire logic hit_mka = (widx == `MICF_W_MKA);
  wire logic hit_mkb = (widx == `MICF_W_MKB);
  wire logic hit_stat = (widx == `MICF_W_STAT);
  wire logic hit_imsk = (widx == `MICF_W_IMSK);
  // writes land on the edge at which the master sees ack
  wire logic wr_go = acc & wb_we_i & wb_ack_o;
  wire logic rd_go = acc & ~wb_we_i & wb_ack_o;
  wire logic [4:0] cidx = widx[4:0];

  // ----------------------------------------
  // per-source control bytes
  // ----------------------------------------
  logic [7:0] ctrl [NSRC];
  logic [NSRC-1:0] req_v;
  logic [NSRC-1:0] mask_v;
  logic [NSRC-1:0] macro_v;
  logic [NSRC-1:0] ctx_v;
  logic [1:0] lvl [NSRC];
  logic [NSRC-1:0] taken;
  logic [NSRC-1:0] elig;
  logic [NSRC-1:0] wr_ctrl;
  logic [NSRC-1:0] wr_mask;
  logic [NSRC-1:0] mask_dat;
  logic [NSRC-1:0] mend;

  logic req_valid_r;
  logic [4:0] req_id_r;

  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : gsrc
      assign wr_ctrl[g] = wr_go & hit_ctrl & (cidx == 5'(g)) & wb_sel_i[0];
      if (g < NMKA) begin : gmka
        assign wr_mask[g] = wr_go & hit_mka & wb_sel_i[g / 8];
        assign mask_dat[g] = wb_dat_i[g];
      end else begin : gmkb
        assign wr_mask[g] = wr_go & hit_mkb & wb_sel_i[0];
        assign mask_dat[g] = wb_dat_i[g - NMKA];
      end
      assign taken[g] = ack_i & req_valid_r & (req_id_r == 5'(g));
      assign mend[g] = macro_end_i & (macro_end_id_i == 5'(g));
      assign req_v[g] = ctrl[g][`MICF_B_REQ];
      assign mask_v[g] = ctrl[g][`MICF_B_MASK];
      assign macro_v[g] = ctrl[g][`MICF_B_MACRO];
      assign ctx_v[g] = ctrl[g][`MICF_B_CTX];
      // the two flags read as a plain binary level
      assign lvl[g] = {ctrl[g][`MICF_B_PRHI], ctrl[g][`MICF_B_PRLO]};
      // a request just taken drops out now, so it is not shown twice
      assign elig[g] = req_v[g] & ~mask_v[g] & ~taken[g];
      micf_src u_src (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(src_evt_i[g]),
        .ack_clr_i(taken[g]),
        .wr_ctrl_i(wr_ctrl[g]),
        .wr_dat_i(wb_dat_i[7:0]),
        .wr_mask_i(wr_mask[g]),
        .mask_dat_i(mask_dat[g]),
        .macro_end_i(mend[g]),
        .ctrl_o(ctrl[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // arbiter
  // ----------------------------------------
  logic sel_found;
  logic [4:0] sel_id;
  logic [1:0] sel_lvl;
  micf_pkg::micf_mode_t sel_mode;

  // strict less-than keeps the lowest index among equal levels
  always_comb begin
    sel_found = 1'b0;
    sel_id = 5'h00;
    sel_lvl = 2'h3;
    for (int i = 0; i < NSRC; i++) begin
      if (elig[i] && (!sel_found || (lvl[i] < sel_lvl))) begin
        sel_found = 1'b1;
        sel_id = 5'(i);
        sel_lvl = lvl[i];
      end
    end
  end

  // macro service takes precedence over the context-switch flag
  always_comb begin
    if (macro_v[sel_id]) begin
      sel_mode = micf_pkg::MICF_MACRO;
    end else if (ctx_v[sel_id]) begin
      sel_mode = micf_pkg::MICF_CTX;
    end else begin
      sel_mode = micf_pkg::MICF_VECT;
    end
  end

  logic [1:0] req_level_r;
  micf_pkg::micf_mode_t req_mode_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_valid_r <= 1'b0;
      req_id_r <= 5'h00;
      req_level_r <= 2'h0;
      req_mode_r <= micf_pkg::MICF_VECT;
    end else begin
      req_valid_r <= sel_found;
      req_id_r <= sel_id;
      req_level_r <= sel_lvl;
      req_mode_r <= sel_mode;
    end
  end

  assign req_valid_o = req_valid_r;
  assign req_id_o = req_id_r;
  assign req_level_o = req_level_r;
  assign req_mode_o = req_mode_r;

  // ----------------------------------------
  // event status, mask and interrupt
  // ----------------------------------------
  logic [`MICF_NEV-1:0] stat_r;
  logic [`MICF_NEV-1:0] imsk_r;
  logic [31:0] dat_r;
  logic ack_r;
  logic irq_r;

  wire logic [`MICF_NEV-1:0] ev = {macro_end_i, ack_i & req_valid_r};
  // clear only what the read returned; a new event in that cycle survives
  wire logic [`MICF_NEV-1:0] stat_clr = (rd_go & hit_stat) ? dat_r[`MICF_NEV-1:0] : '0;
  wire logic [`MICF_NEV-1:0] stat_nxt = (stat_r & ~stat_clr) | ev;
  wire logic imsk_wr = wr_go & hit_imsk & wb_sel_i[0];
  wire logic [`MICF_NEV-1:0] imsk_nxt = imsk_wr ? wb_dat_i[`MICF_NEV-1:0] : imsk_r;

  // ----------------------------------------
  // read mux and bus answer
  // ----------------------------------------
  wire logic [31:0] mka_val = {16'h0000, mask_v[NMKA-1:0]};
  wire logic [31:0] mkb_val = {25'h0000000, mask_v[NSRC-1:NMKA]};
  wire logic [31:0] ctrl_val = {24'h000000, ctrl[cidx]};
  wire logic [31:0] stat_val = {30'h00000000, stat_r};
  wire logic [31:0] imsk_val = {30'h00000000, imsk_r};
  wire logic [31:0] rd_mux = hit_ctrl ? ctrl_val :
                             hit_mka ? mka_val :
                             hit_mkb ? mkb_val :
                             hit_stat ? stat_val :
                             hit_imsk ? imsk_val : 32'h00000000;
  wire logic ack_nxt = acc & ~ack_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
      stat_r <= '0;
      imsk_r <= `MICF_IMSK_RST;
      irq_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      if (ack_nxt && !wb_we_i) begin
        dat_r <= rd_mux;
      end
      stat_r <= stat_nxt;
      imsk_r <= imsk_nxt;
      irq_r <= |(stat_nxt & imsk_nxt);
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign irq_o = irq_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [NSRC-1:0] elig_q;
  logic [NSRC-1:0] mac_q;
  logic [1:0] lvl_q [NSRC];
  logic beaten;
  wire logic mk_wr = |wr_ctrl | |wr_mask;

  always_ff @(posedge clk_i) begin
    elig_q <= elig;
    mac_q <= macro_v;
    lvl_q <= lvl;
  end

  always_comb begin
    beaten = 1'b0;
    for (int j = 0; j < NSRC; j++) begin
      if (elig_q[j] && ((lvl_q[j] < req_level_r) ||
          ((lvl_q[j] == req_level_r) && (5'(j) < req_id_r)))) begin
        beaten = 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr_mka;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && hit_mka && (wb_sel_i[1:0] == 2'b11);
  endsequence

  sequence s_present_macro;
    req_valid_o && (req_mode_o == micf_pkg::MICF_MACRO);
  endsequence

  property p_rst_ctrl;
    $past(rst_i) |-> (ctrl[0] == `MICF_CTRL_RST) && (ctrl[NSRC-1] == `MICF_CTRL_RST);
  endproperty
  a_rst_ctrl: assert property (p_rst_ctrl) else $error("control byte not at reset value");

  property p_set_req;
    (src_evt_i != 23'h000000) |=> ((req_v & $past(src_evt_i)) == $past(src_evt_i));
  endproperty
  a_set_req: assert property (p_set_req) else $error("request flag not set");

  property p_ack_clr;
    ack_i && req_valid_o && !src_evt_i[req_id_o] && !wr_ctrl[req_id_o]
      |=> !req_v[$past(req_id_o)];
  endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("request flag kept after ack");

  property p_mask_hold;
    !mk_wr |=> mask_v == $past(mask_v);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask changed without write");

  property p_mask_alias;
    s_wr_mka |=> (mask_v[NMKA-1:0] == $past(wb_dat_i[NMKA-1:0]));
  endproperty
  a_mask_alias: assert property (p_mask_alias) else $error("mask paths disagree");

  property p_macro_end;
    macro_end_i && (macro_end_id_i < 5'(NSRC)) |=> !macro_v[$past(macro_end_id_i)];
  endproperty
  a_macro_end: assert property (p_macro_end) else $error("macro flag kept at end");

  property p_mode;
    s_present_macro |-> mac_q[req_id_o];
  endproperty
  a_mode: assert property (p_mode) else $error("macro mode without macro flag");

  property p_not_masked;
    req_valid_o |-> elig_q[req_id_o];
  endproperty
  a_not_masked: assert property (p_not_masked) else $error("masked request presented");

  property p_best;
    req_valid_o |-> !beaten;
  endproperty
  a_best: assert property (p_best) else $error("better request was pending");

  property p_found;
    req_valid_o == (|elig_q);
  endproperty
  a_found: assert property (p_found) else $error("valid disagrees with pending set");

endmodule
`default_nettype wire

// [verif/micf_cpu_model.sv]
// cpu core model that takes presented requests
`timescale 1ns/100ps
`default_nettype none

module micf_cpu_model (
  input wire logic clk_i,        // cpu clock
  input wire logic rst_i,        // sync reset, high
  input wire logic req_valid_i,  // request presented
  input wire logic en_i,         // core accepts interrupts
  input wire logic [3:0] wait_i, // stall cycles before taking
  output logic ack_o             // one-cycle take pulse
);
  logic [3:0] cnt_r;
  // ----
  // take after wait_i cycles
  // ----
  // a cycle off after each take, so a stale id is never taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 4'h0;
      ack_o <= 1'b0;
    end else begin
      ack_o <= 1'b0;
      if (ack_o || !req_valid_i || !en_i) begin
        cnt_r <= 4'h0;
      end else if (cnt_r >= wait_i) begin
        ack_o <= 1'b1;
        cnt_r <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/tb_maskable_interrupt_control_flags.sv]
// self-checking bench for the interrupt control flags block
`timescale 1ns/100ps
`default_nettype none
`include "micf_consts.svh"

module tb_maskable_interrupt_control_flags;
  logic clk_i;
  logic rst_i;
  logic cyc;
  logic stb;
  logic we;
  logic [5:0] adr;
  logic [31:0] wdat;
  logic [3:0] sel;
  logic [31:0] rdat;
  logic ack;
  logic [22:0] evt;
  logic cpu_ack;
  logic cpu_en;
  logic [3:0] cpu_wait;
  logic mend;
  logic [4:0] mend_id;
  logic req_valid_o;
  logic [4:0] req_id_o;
  logic [1:0] req_level_o;
  micf_pkg::micf_mode_t req_mode_o;
  logic irq_o;
  int mismatches;
  int checks;
  logic [8:0] seen[$];

  micf_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .src_evt_i(evt), .ack_i(cpu_ack), .macro_end_i(mend),
    .macro_end_id_i(mend_id), .req_valid_o(req_valid_o), .req_id_o(req_id_o),
    .req_level_o(req_level_o), .req_mode_o(req_mode_o), .irq_o(irq_o));
  micf_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_o),
    .en_i(cpu_en), .wait_i(cpu_wait), .ack_o(cpu_ack));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // log what the core took, in order
  always @(posedge clk_i) begin
    if (cpu_ack === 1'b1 && req_valid_o === 1'b1) begin
      seen.push_back({req_id_o, req_level_o, req_mode_o});
    end
  end

  // ----
  // shared tasks
  // ----
  task automatic close_out();
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40) begin
      mismatches++;
      close_out();
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(nm, q, e);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    wrs(a, d, 4'hf);
  endtask

  task automatic wrs(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask

  function automatic logic [5:0] ca(input int n);
    return `MICF_W_CTRL0 + 6'(n);
  endfunction

  task automatic wait_log(input int n);
    int k;
    k = 0;
    while (seen.size() < n && k < 60) begin
      @(posedge clk_i);
      k++;
    end
    if (seen.size() < n) begin
      mismatches++;
      close_out();
    end
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    rd(ca(0), 32'h43, "ctrl0");
    rd(ca(22), 32'h43, "ctrl22");
    rd(`MICF_W_MKA, 32'hffff, "mka");
    rd(`MICF_W_MKB, 32'h7f, "mkb");
    rd(6'h3f, 32'h0, "unmapped");
  endtask

  task automatic t_rw();
    wr(ca(5), 32'h12);
    rd(ca(5), 32'h12, "ctrl5");
    rd(`MICF_W_MKA, 32'hffdf, "mka bit5");
    wr(`MICF_W_MKA, 32'hffff);
    rd(ca(5), 32'h52, "ctrl5 mask");
    wrs(`MICF_W_MKA, 32'h000000ff, 4'h2);
    rd(`MICF_W_MKA, 32'h00ff, "mka lane1");
    wr(`MICF_W_MKA, 32'hffff);
  endtask

  // same level tie, higher level loses, one masked; prompt then slow core
  task automatic t_arb();
    cpu_wait <= 4'h0;
    wr(ca(3), 32'h11);
    wr(ca(7), 32'h21);
    wr(ca(0), 32'h02);
    wr(ca(12), 32'h40);
    rd(`MICF_W_MKA, 32'hff76, "mka ctrl path");
    cpu_en <= 1'b1;
    @(posedge clk_i);
    evt <= 23'h001089;
    @(posedge clk_i);
    evt <= 23'h0;
    wait_log(3);
    chk("take0", 32'(seen[0]), {5'h03, 2'h1, micf_pkg::MICF_CTX});
    chk("take1", 32'(seen[1]), {5'h07, 2'h1, micf_pkg::MICF_MACRO});
    chk("take2", 32'(seen[2]), {5'h00, 2'h2, micf_pkg::MICF_VECT});
    // the last take may land in this very step; let the presented set settle
    @(posedge clk_i);
    chk("valid", 32'(req_valid_o), 32'h0);
    rd(ca(3), 32'h11, "ctrl3 taken");
    rd(ca(12), 32'hc0, "ctrl12 held");
    cpu_wait <= 4'h3;
    wr(`MICF_W_MKA, 32'hef76);
    wait_log(4);
    chk("take3", 32'(seen[3]), {5'h0c, 2'h0, micf_pkg::MICF_VECT});
  endtask

  task automatic t_mend();
    @(posedge clk_i);
    mend_id <= 5'h07;
    mend <= 1'b1;
    @(posedge clk_i);
    mend <= 1'b0;
    rd(ca(7), 32'h01, "ctrl7 macro end");
  endtask

  task automatic t_irq();
    chk("irq masked", 32'(irq_o), 32'h0);
    wr(`MICF_W_IMSK, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("irq raised", 32'(irq_o), 32'h1);
    rd(`MICF_W_STAT, 32'h3, "status");
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 32'(irq_o), 32'h0);
    rd(`MICF_W_STAT, 32'h0, "status clear");
  endtask

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h00;
    wdat = 32'h0;
    sel = 4'hf;
    evt = 23'h0;
    cpu_en = 1'b0;
    cpu_wait = 4'h0;
    mend = 1'b0;
    mend_id = 5'h00;
    mismatches = 0;
    checks = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_rw();
    t_arb();
    t_mend();
    t_irq();
    close_out();
  end
endmodule
`default_nettype wire
